// ### hdl/ohrm_pkg.sv
package ohrm_pkg;
  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_ROM_MAP = 8'h34;
  localparam logic [7:0] OFF_FAIL_LO = 8'h38;
  localparam logic [7:0] OFF_FAIL_HI = 8'h3C;
  localparam logic [7:0] OFF_VENDOR = 8'h40;
  localparam logic [7:0] OFF_CTL_SET = 8'h50;
  localparam logic [7:0] OFF_CTL_CLR = 8'h54;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h60;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h64;
  localparam logic [7:0] OFF_ROM_REQ = 8'h68;
  localparam logic [7:0] OFF_ROM_ADDR = 8'h6C;
  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int ROM_ADDR_LSB = 10;
  localparam int ROM_ADDR_W = 22;
  localparam int SRC_BUS_LSB = 22;
  localparam int SRC_NODE_LSB = 16;
  localparam int CTL_IMG_VALID_BIT = 31;
  localparam int CTL_PHY_PERMIT_BIT = 23;
  localparam logic [31:0] ROM_MAP_RST = 32'h0000_0000;
  localparam logic [31:0] CTL_RST = 32'h0080_0000;
  localparam logic [31:0] CTL_IMPL_MASK = 32'hE0C0_0000;
  localparam logic [47:0] ROM_WIN_LO = 48'hFFFF_F000_0400;
  localparam logic [47:0] ROM_WIN_HI = 48'hFFFF_F000_07FF;
  localparam int IRQ_W = 3;
  localparam int IRQ_POST_ERR = 0;
  localparam int IRQ_ROM_READ = 1;
  localparam int IRQ_BUS_RESET = 2;
endpackage : ohrm_pkg

// ### hdl/ohrm_rom_xlate.sv
module ohrm_rom_xlate
  import ohrm_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // serial-bus read request
  input wire logic req_i,
  input wire logic [47:0] offset_i,
  input wire logic [ROM_ADDR_W-1:0] base_i,
  // result
  output logic hit_o,
  output logic [31:0] addr_o
);
  logic hit_d, hit_q;
  logic [31:0] addr_d, addr_q;

  always_comb
  begin
    hit_d = req_i && (offset_i >= ROM_WIN_LO) && (offset_i <= ROM_WIN_HI);
    addr_d = addr_q;
    if (hit_d)
    begin
      addr_d = {base_i, 10'h000} + {22'h000000, offset_i[9:0]}; // RULE1
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hit_q <= 1'b0;
      addr_q <= 32'h0000_0000;
    end
    else
    begin
      hit_q <= hit_d;
      addr_q <= addr_d;
    end
  end

  assign hit_o = hit_q;
  assign addr_o = addr_q;

  chk_rom_sum: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
    hit_d |=> addr_q == {$past(base_i), 10'h000} + {22'h000000, $past(offset_i[9:0])})
    else $error("rom address sum wrong");
endmodule : ohrm_rom_xlate

// ### hdl/ohrm_irq.sv
module ohrm_irq
  import ohrm_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // events and software access
  input wire logic [IRQ_W-1:0] event_i,
  input wire logic clr_we_i,
  input wire logic mask_we_i,
  input wire logic [IRQ_W-1:0] wdata_i,
  // state
  output logic [IRQ_W-1:0] status_o,
  output logic [IRQ_W-1:0] mask_o,
  output logic irq_o
);
  logic [IRQ_W-1:0] stat_d, stat_q, mask_d, mask_q;
  logic irq_d, irq_q;

  always_comb
  begin
    // set wins over a simultaneous clear
    stat_d = (stat_q & ~(clr_we_i ? wdata_i : '0)) | event_i;
    mask_d = mask_we_i ? wdata_i : mask_q;
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stat_q <= '0;
      mask_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
    end
  end

  assign status_o = stat_q;
  assign mask_o = mask_q;
  assign irq_o = irq_q;
endmodule : ohrm_irq

// ### hdl/ohrm_regs.sv
// Contract
// RULE1: rom window quadlet read address is map base plus offset low ten bits.
// RULE2: map base bits 31..10 are read/write and reset to zero.
// RULE3: map register bits 9..0 always read zero.
// RULE4: a posted write data error captures the request into the error pair.
// RULE5: low error register holds offset bits 31..0, read only.
// RULE6: high error register bits 15..0 hold offset bits 47..32, hardware only.
// RULE7: high error bits 31..22 bus number, 21..16 node number.
// RULE8: error registers have no defined reset value.
// RULE9: vendor register is read only and returns a fixed company code.
// RULE10: control register set at 50h, cleared at 54h.
// RULE11: control register resets to bit 23 only.
// RULE12: with image valid clear, bus reset leaves map register unchanged.
// RULE13: phy program permit bit is loaded from the serial eeprom.
// RULE14: zero bits written leave control bits; both addresses read control value.
//
// The implementer's own choice: the Wishbone interface to the registers.
module ohrm_regs
  import ohrm_pkg::*;
#(
  parameter logic [23:0] VENDOR_CODE = 24'h5A5A5A // arbitrary value
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // serial-bus side
  input wire logic rom_rd_req_i,
  input wire logic [47:0] rom_rd_offset_i,
  input wire logic post_err_i,
  input wire logic [47:0] post_err_offset_i,
  input wire logic [15:0] post_err_source_i,
  input wire logic bus_reset_i,
  input wire logic [ROM_ADDR_W-1:0] bus_reset_rom_base_i,
  // serial eeprom load
  input wire logic eeprom_load_i,
  input wire logic eeprom_permit_i,
  // outputs
  output logic rom_rd_hit_o,
  output logic [31:0] rom_rd_addr_o,
  output logic bus_info_image_valid_o,
  output logic phy_program_permit_o,
  output logic irq_o
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [ROM_ADDR_W-1:0] rom_window_base_addr_d, rom_window_base_addr_q;
  logic [31:0] failed_dest_offset_low_d, failed_dest_offset_low_q;
  logic [15:0] failed_dest_offset_high_d, failed_dest_offset_high_q;
  logic [15:0] failed_requester_ident_d, failed_requester_ident_q;
  logic [31:0] ctl_d, ctl_q;
  logic [31:0] rdat_d, rdat_q;
  logic ack_d, ack_q, err_d, err_q;
  logic img_q, permit_q;
  logic req, wr, mapped;
  logic [31:0] wmask, ctl_rd, set_mask;
  logic irq_clr_we, irq_mask_we;
  logic [IRQ_W-1:0] irq_stat, irq_mask, irq_ev;
  logic rom_hit;
  logic [31:0] rom_addr;

  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : lane_mask

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == OFF_ROM_MAP) || (a == OFF_FAIL_LO) || (a == OFF_FAIL_HI)
      || (a == OFF_VENDOR) || (a == OFF_CTL_SET) || (a == OFF_CTL_CLR)
      || (a == OFF_IRQ_STAT) || (a == OFF_IRQ_MASK) || (a == OFF_ROM_REQ)
      || (a == OFF_ROM_ADDR);
  endfunction : known_addr

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  // one cycle answer, then ack drops for a cycle so a held request is not taken twice
  assign req = cyc_i && stb_i && !ack_q && !err_q;
  assign mapped = known_addr(adr_i);
  assign wr = req && we_i && mapped;
  assign wmask = lane_mask(sel_i);
  assign ctl_rd = ctl_q & CTL_IMPL_MASK;
  // permit bit is clear-only: software may drop it but never grant it
  assign set_mask = CTL_IMPL_MASK & ~(32'h0000_0001 << CTL_PHY_PERMIT_BIT);
  assign irq_clr_we = wr && (adr_i == OFF_IRQ_STAT);
  assign irq_mask_we = wr && (adr_i == OFF_IRQ_MASK);
  assign irq_ev = {bus_reset_i, rom_hit, post_err_i};

  always_comb
  begin
    ack_d = req && mapped;
    err_d = req && !mapped;
    rdat_d = rdat_q;
    if (req && !we_i)
    begin
      unique case (adr_i)
        OFF_ROM_MAP: rdat_d = {rom_window_base_addr_q, 10'h000}; // RULE3
        OFF_FAIL_LO: rdat_d = failed_dest_offset_low_q; // RULE5
        OFF_FAIL_HI: rdat_d = {failed_requester_ident_q, failed_dest_offset_high_q}; // RULE7
        OFF_VENDOR: rdat_d = {8'h00, VENDOR_CODE}; // RULE9
        OFF_CTL_SET, OFF_CTL_CLR: rdat_d = ctl_rd; // RULE14
        OFF_IRQ_STAT: rdat_d = {29'h0, irq_stat};
        OFF_IRQ_MASK: rdat_d = {29'h0, irq_mask};
        OFF_ROM_REQ: rdat_d = {31'h0, rom_rd_hit_o};
        OFF_ROM_ADDR: rdat_d = rom_addr;
        default: rdat_d = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_comb
  begin
    rom_window_base_addr_d = rom_window_base_addr_q;
    if (bus_reset_i && img_q)
    begin
      rom_window_base_addr_d = bus_reset_rom_base_i; // RULE12
    end
    if (wr && adr_i == OFF_ROM_MAP)
    begin
      rom_window_base_addr_d = (rom_window_base_addr_q & ~wmask[31:10])
        | (dat_i[31:10] & wmask[31:10]); // RULE2
    end
    failed_dest_offset_low_d = failed_dest_offset_low_q;
    failed_dest_offset_high_d = failed_dest_offset_high_q;
    failed_requester_ident_d = failed_requester_ident_q;
    if (post_err_i)
    begin
      failed_dest_offset_low_d = post_err_offset_i[31:0]; // RULE4 RULE5
      failed_dest_offset_high_d = post_err_offset_i[47:32]; // RULE6
      failed_requester_ident_d = post_err_source_i; // RULE7
    end
    ctl_d = ctl_q;
    if (wr && adr_i == OFF_CTL_SET)
    begin
      ctl_d = ctl_q | (dat_i & wmask & set_mask); // RULE10 RULE14
    end
    if (wr && adr_i == OFF_CTL_CLR)
    begin
      ctl_d = ctl_q & ~(dat_i & wmask); // RULE10 RULE14
    end
    if (eeprom_load_i)
    begin
      ctl_d[CTL_PHY_PERMIT_BIT] = eeprom_permit_i; // RULE13
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rom_window_base_addr_q <= ROM_MAP_RST[31:10]; // RULE2
      ctl_q <= CTL_RST; // RULE11
      rdat_q <= 32'h0000_0000;
      ack_q <= 1'b0;
      err_q <= 1'b0;
      img_q <= 1'b0;
      permit_q <= 1'b1;
    end
    else
    begin
      rom_window_base_addr_q <= rom_window_base_addr_d;
      ctl_q <= ctl_d;
      rdat_q <= rdat_d;
      ack_q <= ack_d;
      err_q <= err_d;
      img_q <= ctl_d[CTL_IMG_VALID_BIT];
      permit_q <= ctl_d[CTL_PHY_PERMIT_BIT];
    end
  end

  // capture registers have no reset value
  always_ff @(posedge clk_i)
  begin
    failed_dest_offset_low_q <= failed_dest_offset_low_d; // RULE8
    failed_dest_offset_high_q <= failed_dest_offset_high_d;
    failed_requester_ident_q <= failed_requester_ident_d;
  end

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  ohrm_rom_xlate u_xlate (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_i(rom_rd_req_i), // RULE1
    .offset_i(rom_rd_offset_i),
    .base_i(rom_window_base_addr_q),
    .hit_o(rom_hit),
    .addr_o(rom_addr)
  );

  ohrm_irq u_irq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .event_i(irq_ev),
    .clr_we_i(irq_clr_we),
    .mask_we_i(irq_mask_we),
    .wdata_i(dat_i[IRQ_W-1:0]),
    .status_o(irq_stat),
    .mask_o(irq_mask),
    .irq_o(irq_o)
  );

  assign dat_o = rdat_q;
  assign ack_o = ack_q;
  assign err_o = err_q;
  assign rom_rd_hit_o = rom_hit;
  assign rom_rd_addr_o = rom_addr;
  assign bus_info_image_valid_o = img_q;
  assign phy_program_permit_o = permit_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_clr_write;
    wr && adr_i == OFF_CTL_CLR;
  endsequence

  sequence s_set_write;
    wr && adr_i == OFF_CTL_SET && !eeprom_load_i;
  endsequence

  sequence s_bus_reload;
    bus_reset_i && img_q && !(wr && adr_i == OFF_ROM_MAP);
  endsequence

  chk_map_low_zero: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
    ack_q && $past(adr_i) == OFF_ROM_MAP && !$past(we_i) |-> dat_o[9:0] == 10'h000)
    else $error("map low bits not zero");
  chk_map_write: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
    wr && adr_i == OFF_ROM_MAP && sel_i == 4'hF && !(bus_reset_i && img_q)
    |=> rom_window_base_addr_q == $past(dat_i[31:10]))
    else $error("map write lost");
  chk_map_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
    bus_reset_i && !img_q && !(wr && adr_i == OFF_ROM_MAP) |=> $stable(rom_window_base_addr_q))
    else $error("map changed on bus reset");
  chk_err_capture: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
    post_err_i |=> failed_dest_offset_low_q == $past(post_err_offset_i[31:0])
      && failed_dest_offset_high_q == $past(post_err_offset_i[47:32]))
    else $error("posted error not captured");
  chk_err_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
    !post_err_i |=> $stable(failed_dest_offset_high_q) && $stable(failed_requester_ident_q))
    else $error("error register changed without error");
  chk_vendor_const: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
    ack_q && $past(adr_i) == OFF_VENDOR && !$past(we_i) |-> dat_o == {8'h00, VENDOR_CODE})
    else $error("vendor code wrong");
  chk_ctl_clear: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
    (s_clr_write and !eeprom_load_i) |=> (ctl_q & $past(dat_i & wmask)) == 32'h0000_0000)
    else $error("clear write left bits set");
  chk_ctl_reset: assert property (@(posedge clk_i) // RULE11
    $past(rst_i) |-> ctl_q == CTL_RST)
    else $error("control reset value wrong");
  chk_ctl_keep: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
    wr && adr_i == OFF_CTL_SET && !eeprom_load_i |=> (ctl_q & $past(ctl_q)) == $past(ctl_q))
    else $error("set write cleared bits");
  chk_permit_load: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
    eeprom_load_i |=> phy_program_permit_o == $past(eeprom_permit_i))
    else $error("permit not loaded");
  chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_q |=> !ack_q && !err_q)
    else $error("ack held longer than one cycle");
  chk_err_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_q && !err_q && !mapped |=> err_q && !ack_q)
    else $error("unmapped access not refused");
  chk_ctl_set_bits: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
    s_set_write |=> (ctl_q & $past(dat_i & wmask & set_mask))
      == $past(dat_i & wmask & set_mask))
    else $error("set write did not set bits");
  chk_permit_no_set: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
    s_set_write |=> ctl_q[CTL_PHY_PERMIT_BIT] == $past(ctl_q[CTL_PHY_PERMIT_BIT]))
    else $error("set write changed permit bit");
  chk_map_reload: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
    s_bus_reload |=> rom_window_base_addr_q == $past(bus_reset_rom_base_i))
    else $error("map not reloaded on bus reset");
  chk_low_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
    !post_err_i |=> $stable(failed_dest_offset_low_q))
    else $error("low error register changed without error");
  chk_low_read: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
    ack_q && $past(adr_i) == OFF_FAIL_LO && !$past(we_i) |-> dat_o == $past(failed_dest_offset_low_q))
    else $error("low error register read wrong");
  chk_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o == |(irq_stat & irq_mask))
    else $error("interrupt level wrong");
  chk_img_mirror: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
    bus_info_image_valid_o == ctl_q[CTL_IMG_VALID_BIT])
    else $error("image valid output wrong");
  chk_permit_mirror: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
    phy_program_permit_o == ctl_q[CTL_PHY_PERMIT_BIT])
    else $error("permit output wrong");
  chk_rom_outside: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
    rom_rd_req_i && (rom_rd_offset_i < ROM_WIN_LO || rom_rd_offset_i > ROM_WIN_HI)
    |=> !rom_rd_hit_o)
    else $error("rom hit outside window");
endmodule : ohrm_regs

// ### sim/ohrm_far_model.sv
module ohrm_far_model
(
  // clock
  input wire logic clk_i,
  // serial-bus requesters
  output logic rom_rd_req_o,
  output logic [47:0] rom_rd_offset_o,
  output logic post_err_o,
  output logic [47:0] post_err_offset_o,
  output logic [15:0] post_err_source_o,
  output logic bus_reset_o,
  output logic [21:0] bus_reset_rom_base_o,
  // serial eeprom
  output logic eeprom_load_o,
  output logic eeprom_permit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // one-cycle pulses; data inverted after so stale values never match
  // ----------------------------------------
  initial
  begin
    {rom_rd_req_o, post_err_o, bus_reset_o, eeprom_load_o} = 4'h0;
    rom_rd_offset_o = '0;
    post_err_offset_o = '0;
    post_err_source_o = '0;
    bus_reset_rom_base_o = '0;
    eeprom_permit_o = 1'b0;
  end
  task automatic rom_read(input logic [47:0] o);
    @(posedge clk_i);
    rom_rd_req_o <= 1'b1;
    rom_rd_offset_o <= o;
    @(posedge clk_i);
    rom_rd_req_o <= 1'b0;
    rom_rd_offset_o <= ~o;
  endtask : rom_read
  task automatic post_error(input logic [47:0] o, input logic [15:0] s);
    @(posedge clk_i);
    post_err_o <= 1'b1;
    post_err_offset_o <= o;
    post_err_source_o <= s;
    @(posedge clk_i);
    post_err_o <= 1'b0;
    post_err_offset_o <= ~o;
    post_err_source_o <= ~s;
  endtask : post_error
  task automatic bus_reset(input logic [21:0] b);
    @(posedge clk_i);
    bus_reset_o <= 1'b1;
    bus_reset_rom_base_o <= b;
    @(posedge clk_i);
    bus_reset_o <= 1'b0;
    bus_reset_rom_base_o <= ~b;
  endtask : bus_reset
  task automatic eeprom_load(input logic p);
    @(posedge clk_i);
    eeprom_load_o <= 1'b1;
    eeprom_permit_o <= p;
    @(posedge clk_i);
    eeprom_load_o <= 1'b0;
    eeprom_permit_o <= ~p;
  endtask : eeprom_load
endmodule : ohrm_far_model

// ### sim/ohci_rom_map_posted_write_regs_tb.sv
module ohci_rom_map_posted_write_regs_tb;
  import ohrm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] VCODE = 24'h3C3C3C; // arbitrary value
  logic clk_i, rst_i, cyc, stb, we, ack, err, hit, img, permit, irq, last_err;
  logic rreq, perr, brst, eload, eperm;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, rdat, raddr, q;
  logic [47:0] roff, poff;
  logic [15:0] psrc;
  logic [21:0] bbase;
  int errors, check_count;
  ohrm_regs #(.VENDOR_CODE(VCODE)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat),
    .ack_o(ack), .err_o(err), .rom_rd_req_i(rreq), .rom_rd_offset_i(roff),
    .post_err_i(perr), .post_err_offset_i(poff), .post_err_source_i(psrc),
    .bus_reset_i(brst), .bus_reset_rom_base_i(bbase), .eeprom_load_i(eload),
    .eeprom_permit_i(eperm), .rom_rd_hit_o(hit), .rom_rd_addr_o(raddr),
    .bus_info_image_valid_o(img), .phy_program_permit_o(permit), .irq_o(irq));
  ohrm_far_model far_u (.clk_i(clk_i), .rom_rd_req_o(rreq), .rom_rd_offset_o(roff),
    .post_err_o(perr), .post_err_offset_o(poff), .post_err_source_o(psrc),
    .bus_reset_o(brst), .bus_reset_rom_base_o(bbase), .eeprom_load_o(eload),
    .eeprom_permit_o(eperm));
  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // waits for ack or err; only the watchdog ends a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    do
      @(posedge clk_i);
    while (ack !== 1'b1 && err !== 1'b1);
    q = rdat;
    last_err = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic t_reset;
    rd(OFF_ROM_MAP, 32'h0);
    rd(OFF_CTL_SET, 32'h0080_0000);
    rd(OFF_CTL_CLR, 32'h0080_0000);
    wb(1'b1, OFF_VENDOR, 32'hFFFF_FFFF);
    rd(OFF_VENDOR, {8'h00, VCODE});
    chk(32'({permit, img, irq}), 32'h4);
    $display("test reset done");
  endtask : t_reset
  task automatic t_map;
    wb(1'b1, OFF_ROM_MAP, 32'hFFFF_FFFF);
    rd(OFF_ROM_MAP, 32'hFFFF_FC00);
    wb(1'b1, OFF_ROM_MAP, 32'h1234_5EDF);
    rd(OFF_ROM_MAP, 32'h1234_5C00);
    wb(1'b0, 8'h44, 32'h0);
    chk(32'(last_err), 32'h1);
    $display("test map done");
  endtask : t_map
  task automatic t_rom;
    far_u.rom_read(48'hFFFF_F000_07FC);
    @(negedge clk_i);
    chk({31'h0, hit}, 32'h1);
    chk(raddr, 32'h1234_5FFC);
    far_u.rom_read(48'hFFFF_F000_0800);
    @(negedge clk_i);
    chk({31'h0, hit}, 32'h0);
    rd(OFF_IRQ_STAT, 32'h2);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, OFF_IRQ_MASK, 32'h2);
    @(negedge clk_i);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, OFF_IRQ_STAT, 32'h2);
    @(negedge clk_i);
    chk({31'h0, irq}, 32'h0);
    $display("test rom done");
  endtask : t_rom
  task automatic t_post;
    far_u.post_error(48'hABCD_1234_5678, {10'h2A5, 6'h15});
    wb(1'b1, OFF_FAIL_LO, 32'h0);
    wb(1'b1, OFF_FAIL_HI, 32'h0);
    rd(OFF_FAIL_LO, 32'h1234_5678);
    rd(OFF_FAIL_HI, {10'h2A5, 6'h15, 16'hABCD});
    chk({16'h0000, q[15:0]}, 32'h0000_ABCD);
    rd(OFF_IRQ_STAT, 32'h1);
    $display("test post done");
  endtask : t_post
  task automatic t_ctl;
    wb(1'b1, OFF_CTL_CLR, 32'hFFFF_FFFF);
    rd(OFF_CTL_SET, 32'h0);
    chk({31'h0, permit}, 32'h0);
    wb(1'b1, OFF_CTL_SET, 32'hFFFF_FFFF);
    rd(OFF_CTL_CLR, 32'hE040_0000);
    wb(1'b1, OFF_CTL_CLR, 32'h2000_0000);
    rd(OFF_CTL_SET, 32'hC040_0000);
    far_u.eeprom_load(1'b1);
    rd(OFF_CTL_SET, 32'hC0C0_0000);
    chk({30'h0, img, permit}, 32'h3);
    $display("test control done");
  endtask : t_ctl
  task automatic t_bus_reset;
    far_u.bus_reset(22'h0ABCDE);
    rd(OFF_ROM_MAP, {22'h0ABCDE, 10'h0});
    wb(1'b1, OFF_CTL_CLR, 32'h8000_0000);
    far_u.bus_reset(22'h155555);
    rd(OFF_ROM_MAP, {22'h0ABCDE, 10'h0});
    $display("test bus reset done");
  endtask : t_bus_reset
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial
  begin
    repeat (5000) @(posedge clk_i);
    errors++;
    tally_and_finish();
  end
  initial
  begin
    {rst_i, cyc, stb, we, adr, sel, dat} = {1'b1, 3'h0, 8'h0, 4'h0, 32'h0};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_map();
    t_rom();
    t_post();
    t_ctl();
    t_bus_reset();
    // second reset mid-run: all but the capture pair return to reset state
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    tally_and_finish();
  end
endmodule : ohci_rom_map_posted_write_regs_tb
